// [src/motor_gate_consts.vh]
`ifndef MOTOR_GATE_CONSTS_VH
`define MOTOR_GATE_CONSTS_VH
// register word offsets (word addresses on the 16-bit bus)
`define OFS_GATE_CTRL 3'h0
`define OFS_SUBCOUNTER 3'h1
`define OFS_DEAD_TIME 3'h2
`define OFS_HALF_PERIOD 3'h3
`define OFS_HALF_PERIOD_BUF 3'h4
// gate-control fields
`define GC_RSVD_BIT 7
`define GC_ENABLE_BIT 6
`define GC_REV_PWM_BIT 5
`define GC_POS_PWM_BIT 4
`define GC_FB_BIT 3
// reset values
`define GC_RESET 8'h80
`define SUBCNT_RESET 16'h0000
`define DEAD_TIME_RESET 16'hFFFF
`define HALF_PERIOD_RESET 16'hFFFF
`define HALF_PERIOD_BUF_RESET 16'hFFFF
// timer modes
`define MODE_OTHER 2'h0
`define MODE_RESET_SYNC 2'h1
`define MODE_COMPLEMENTARY 2'h2
`endif

// [src/phase_decode.v]
`timescale 1ns/100ps
// phase code {w,v,u} to {w,v,u reverse, w,v,u positive}
module phase_decode (
  input wire [2:0] code_i,
  output reg [5:0] on_o
);
  always @*
  begin
    case (code_i)
      3'h1: on_o = 6'h21;
      3'h2: on_o = 6'h0A;
      3'h3: on_o = 6'h22;
      3'h4: on_o = 6'h14;
      3'h5: on_o = 6'h11;
      3'h6: on_o = 6'h0C;
      default: on_o = 6'h00;
    endcase
  end
endmodule // phase_decode

// [src/motor_gate_ctrl.v]
`timescale 1ns/100ps
`include "motor_gate_consts.vh"
module motor_gate_ctrl (
  input wire CLK_I,
  input wire SRST_I,
  input wire [2:0] ADDR_I,
  input wire WR_I,
  input wire RD_I,
  input wire [1:0] BE_I,
  input wire [15:0] WDATA_I,
  output reg [15:0] RDATA_O,
  output reg ACC_ERR_O,
  input wire [1:0] TIMER_MODE_I,
  input wire COUNTER_RESTART_I,
  input wire SUBCNT_LOAD_I,
  input wire [15:0] SUBCNT_LOAD_VAL_I,
  input wire SUBCNT_DOWN_START_I,
  input wire PERIOD_XFER_I,
  input wire [2:0] CAPTURE_PHASE_I,
  input wire [5:0] PWM_WAVE_I,
  input wire [5:0] LEVEL_ON_I,
  output reg [5:0] PHASE_OUT_O,
  output reg LOAD_COUNTER_THREE_O,
  output reg [15:0] COUNTER_THREE_LOAD_O,
  output reg SUBCNT_TURN_O
);
  // gate register keeps bits 6:0; bit 7 is a constant one on reads
  reg [6:0] gate_q;
  reg [15:0] subcnt_q;
  reg subcnt_down_q;
  reg [15:0] dead_time_q;
  reg [15:0] half_period_q;
  reg [15:0] half_period_buf_q;
  reg [2:0] cap_meta_q;
  reg [2:0] cap_sync_q;
  reg [15:0] rdata_d;
  reg acc_err_d;
  wire [5:0] phase_d;
  wire [7:0] gate_reset;
  wire [7:0] gate_rd;
  wire pwm_mode;
  wire comp_mode;
  wire [2:0] phase_code;
  wire [5:0] phase_on;
  wire full_word;
  wire bus_active;
  wire sel_gate;
  wire sel_subcnt;
  wire sel_dead;
  wire sel_half;
  wire sel_buf;
  wire sel_none;
  wire gate_wr;
  wire dead_wr;
  wire half_wr;
  wire buf_wr;
  wire narrow_err;
  wire match;
  genvar g;

  assign gate_reset = `GC_RESET;
  assign gate_rd = {1'b1, gate_q};
  assign pwm_mode = (TIMER_MODE_I == `MODE_COMPLEMENTARY) ||
                    (TIMER_MODE_I == `MODE_RESET_SYNC);
  assign comp_mode = (TIMER_MODE_I == `MODE_COMPLEMENTARY);
  assign full_word = (BE_I == 2'h3);
  assign bus_active = WR_I || RD_I;
  assign sel_gate = (ADDR_I == `OFS_GATE_CTRL);
  assign sel_subcnt = (ADDR_I == `OFS_SUBCOUNTER);
  assign sel_dead = (ADDR_I == `OFS_DEAD_TIME);
  assign sel_half = (ADDR_I == `OFS_HALF_PERIOD);
  assign sel_buf = (ADDR_I == `OFS_HALF_PERIOD_BUF);
  assign sel_none = !(sel_gate || sel_subcnt || sel_dead || sel_half ||
                      sel_buf);
  // gate register is 8-bit: low lane carries it, either access width ok
  assign gate_wr = WR_I && sel_gate && BE_I[0];
  // 16-bit registers drop any partial-width write
  assign dead_wr = WR_I && full_word && sel_dead;
  assign half_wr = WR_I && full_word && sel_half;
  assign buf_wr = WR_I && full_word && sel_buf;
  assign narrow_err = !sel_gate && !full_word;
  assign phase_code = gate_q[`GC_FB_BIT] ? gate_q[2:0] :
                      cap_sync_q;
  assign match = (subcnt_q == half_period_q);

  phase_decode u_phase_decode (
    .code_i(phase_code),
    .on_o(phase_on)
  );

  // capture inputs come from pins: two flops before use
  always @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      cap_meta_q <= 3'h0;
      cap_sync_q <= 3'h0;
    end
    else
    begin
      cap_meta_q <= CAPTURE_PHASE_I;
      cap_sync_q <= cap_meta_q;
    end
  end

  always @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      gate_q <= gate_reset[6:0];
    end
    else if (gate_wr)
    begin
      gate_q <= WDATA_I[6:0];
    end
  end

  always @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      dead_time_q <= `DEAD_TIME_RESET;
    end
    else if (dead_wr)
    begin
      dead_time_q <= WDATA_I;
    end
  end

  always @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      half_period_buf_q <= `HALF_PERIOD_BUF_RESET;
    end
    else if (buf_wr)
    begin
      half_period_buf_q <= WDATA_I;
    end
  end

  // a bus write in the transfer cycle wins: it is the newer intent
  always @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      half_period_q <= `HALF_PERIOD_RESET;
    end
    else if (half_wr)
    begin
      half_period_q <= WDATA_I;
    end
    else if (PERIOD_XFER_I)
    begin
      half_period_q <= half_period_buf_q;
    end
  end

  // subcounter has no bus write path, so writes leave it alone
  always @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      subcnt_q <= `SUBCNT_RESET;
      subcnt_down_q <= 1'b0;
    end
    else if (!comp_mode)
    begin
      subcnt_q <= `SUBCNT_RESET;
      subcnt_down_q <= 1'b0;
    end
    else if (SUBCNT_LOAD_I)
    begin
      subcnt_q <= SUBCNT_LOAD_VAL_I;
    end
    else if (SUBCNT_DOWN_START_I)
    begin
      subcnt_down_q <= 1'b1;
    end
    else if (subcnt_down_q && match)
    begin
      subcnt_down_q <= 1'b0;
      subcnt_q <= subcnt_q + 16'h0001;
    end
    else if (subcnt_down_q)
    begin
      subcnt_q <= subcnt_q - 16'h0001;
    end
    else
    begin
      subcnt_q <= subcnt_q + 16'h0001;
    end
  end

  // turn pulse is registered: high in the cycle after the down count meets the half period
  always @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      SUBCNT_TURN_O <= 1'b0;
    end
    else
    begin
      SUBCNT_TURN_O <= comp_mode && !SUBCNT_LOAD_I &&
                       !SUBCNT_DOWN_START_I && subcnt_down_q && match;
    end
  end

  // load value is the dead time as it stood before the restart edge
  always @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      LOAD_COUNTER_THREE_O <= 1'b0;
      COUNTER_THREE_LOAD_O <= 16'h0000;
    end
    else
    begin
      LOAD_COUNTER_THREE_O <= comp_mode && COUNTER_RESTART_I;
      COUNTER_THREE_LOAD_O <= dead_time_q;
    end
  end

  // per output: positive bits 2:0 use bit 4, reverse bits 5:3 use bit 5
  generate
    for (g = 0; g < 6; g = g + 1)
    begin : g_out
      reg out_d;
      always @*
      begin
        if (!pwm_mode || !gate_q[`GC_ENABLE_BIT])
        begin
          out_d = PWM_WAVE_I[g];
        end
        else if (!phase_on[g])
        begin
          // off pins rest at the inactive level
          out_d = ~LEVEL_ON_I[g];
        end
        else if (gate_q[(g < 3) ? `GC_POS_PWM_BIT : `GC_REV_PWM_BIT])
        begin
          out_d = PWM_WAVE_I[g];
        end
        else
        begin
          out_d = LEVEL_ON_I[g];
        end
      end
      assign phase_d[g] = out_d;
    end
  endgenerate

  always @*
  begin
    rdata_d = 16'h0000;
    acc_err_d = 1'b0;
    if (sel_gate)
    begin
      rdata_d = {8'h00, gate_rd};
    end
    else if (sel_subcnt)
    begin
      rdata_d = subcnt_q;
    end
    else if (sel_dead)
    begin
      rdata_d = dead_time_q;
    end
    else if (sel_half)
    begin
      rdata_d = half_period_q;
    end
    else if (sel_buf)
    begin
      rdata_d = half_period_buf_q;
    end
    if (sel_none || narrow_err)
    begin
      acc_err_d = 1'b1;
    end
    if (!bus_active)
    begin
      acc_err_d = 1'b0;
    end
    if (!RD_I || acc_err_d)
    begin
      rdata_d = 16'h0000;
    end
  end

  always @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      RDATA_O <= 16'h0000;
      ACC_ERR_O <= 1'b0;
      PHASE_OUT_O <= 6'h00;
    end
    else
    begin
      RDATA_O <= rdata_d;
      ACC_ERR_O <= acc_err_d;
      PHASE_OUT_O <= phase_d;
    end
  end
endmodule // motor_gate_ctrl

// [sim/motor_gate_ctrl_properties.sv]
`timescale 1ns/100ps
module motor_gate_chk (
  input wire CLK_I, SRST_I, WR_I, RD_I, ACC_ERR_O,
  input wire COUNTER_RESTART_I, LOAD_COUNTER_THREE_O, SUBCNT_TURN_O,
  input wire [2:0] ADDR_I,
  input wire [1:0] BE_I, TIMER_MODE_I,
  input wire [5:0] PWM_WAVE_I, PHASE_OUT_O,
  input wire [15:0] WDATA_I, RDATA_O, COUNTER_THREE_LOAD_O
);
  // shadow of the dead time, kept so loads can be tied to the last write
  reg [15:0] dt_q;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  always @(posedge CLK_I)
    if (SRST_I)
      dt_q <= 16'hFFFF;
    else if (WR_I && ADDR_I == 3'h2 && BE_I == 2'h3)
      dt_q <= WDATA_I;
  chk_narrow_err: assert property (
    (WR_I | RD_I) && ADDR_I != 0 && ADDR_I < 5 && BE_I != 3 |=> ACC_ERR_O)
    else $error("narrow access not flagged");
  chk_gate_top: assert property (
    RD_I && ADDR_I == 0 && BE_I[0] |=> RDATA_O[7]) else $error("bit 7 low");
  chk_sub_quiet: assert property (
    WR_I && ADDR_I == 1 && BE_I == 3 |=> !ACC_ERR_O) else $error("sub write");
  chk_dead_read: assert property (
    RD_I && !WR_I && ADDR_I == 2 && BE_I == 3 |=> RDATA_O == $past(dt_q))
    else $error("dead time read");
  chk_dead_load: assert property (
    COUNTER_RESTART_I && TIMER_MODE_I == 2 |=> LOAD_COUNTER_THREE_O &&
    COUNTER_THREE_LOAD_O == $past(dt_q)) else $error("dead time load");
  chk_plain_pwm: assert property (
    TIMER_MODE_I == 0 |=> PHASE_OUT_O == $past(PWM_WAVE_I))
    else $error("ordinary output");
  chk_turn_mode: assert property (
    SUBCNT_TURN_O |-> $past(TIMER_MODE_I) == 2) else $error("turn mode");
  chk_sub_zero: assert property (
    RD_I && ADDR_I == 1 && TIMER_MODE_I != 2 && $past(TIMER_MODE_I) != 2
    |=> RDATA_O == 0) else $error("subcounter not zero");
endmodule // motor_gate_chk
bind motor_gate_ctrl motor_gate_chk u_chk (.*);

// [sim/inverter_model.sv]
`timescale 1ns/100ps
module inverter_model (
  input wire clk_i,
  input wire [5:0] gate_i, level_on_i,
  input wire [2:0] rotor_i,
  output reg [2:0] hall_o,
  output wire shoot_o
);
  // both switches of one leg on would short the supply
  wire [5:0] on = ~(gate_i ^ level_on_i);
  assign shoot_o = |(on[2:0] & on[5:3]);
  always @(posedge clk_i)
    hall_o <= rotor_i;
endmodule // inverter_model

// [sim/testbench.sv]
`timescale 1ns/100ps
module testbench;
  reg clk = 0, rst = 1, wr = 0, rd = 0, rs = 0, ld = 0, dn = 0, px = 0, e;
  reg [2:0] ad = 0, rot = 0;
  reg [1:0] be = 3, md = 0;
  reg [15:0] wd = 0, lv = 0, r, v;
  reg [5:0] pw = 0, lo = 6'h3F;
  wire [15:0] rdat, c3;
  wire err, l3, turn, sh;
  wire [5:0] ph;
  wire [2:0] hall;
  integer bad_count = 0, checks_done = 0, i;
  always #5 clk = ~clk;
  motor_gate_ctrl u_motor_gate_ctrl (.CLK_I(clk), .SRST_I(rst),
    .ADDR_I(ad), .WR_I(wr), .RD_I(rd), .BE_I(be), .WDATA_I(wd),
    .RDATA_O(rdat), .ACC_ERR_O(err), .TIMER_MODE_I(md),
    .COUNTER_RESTART_I(rs), .SUBCNT_LOAD_I(ld), .SUBCNT_LOAD_VAL_I(lv),
    .SUBCNT_DOWN_START_I(dn), .PERIOD_XFER_I(px), .CAPTURE_PHASE_I(hall),
    .PWM_WAVE_I(pw), .LEVEL_ON_I(lo), .PHASE_OUT_O(ph),
    .LOAD_COUNTER_THREE_O(l3), .COUNTER_THREE_LOAD_O(c3),
    .SUBCNT_TURN_O(turn));
  inverter_model u_inverter_model (.clk_i(clk), .gate_i(ph),
    .level_on_i(lo), .rotor_i(rot), .hall_o(hall), .shoot_o(sh));
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task cmp(input [63:0] n, input [15:0] x, input [15:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== x)
      begin
        bad_count = bad_count + 1;
        $display("MISMATCH %0s exp %h got %h", n, x, g);
      end
    end
  endtask
  task wt(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  // strobes last one cycle; answer is sampled just after the taking edge
  task acc(input w, input [2:0] a, input [1:0] b, input [15:0] d);
    begin
      @(posedge clk);
      {wr, rd, ad, be, wd} <= {w, ~w, a, b, d};
      @(posedge clk);
      {wr, rd} <= 2'b00;
      #1 r = rdat;
      e = err;
    end
  endtask
  function [5:0] ph_exp(input [2:0] c, input p, input n);
    reg [5:0] m, k;
    begin
      m = c == 1 ? 6'h21 : c == 2 ? 6'h0A : c == 3 ? 6'h22 : c == 4 ? 6'h14
        : c == 5 ? 6'h11 : c == 6 ? 6'h0C : 6'h00;
      k = {{3{n}}, {3{p}}};
      ph_exp = (m & k & pw) | (m & ~k & lo) | (~m & ~lo);
    end
  endfunction
  initial begin
    i = $urandom(8);
    pw <= $urandom;
    repeat (5) @(posedge clk);
    rst <= 0;
    for (i = 0; i < 5; i = i + 1)
    begin
      acc(0, i, i ? 3 : 1, 0);
      cmp("reset", i == 0 ? 16'h80 : i == 1 ? 0 : 16'hFFFF, i ? r : r[7:0]);
    end
    for (i = 2; i < 5; i = i + 1)
    begin
      v = $urandom;
      acc(1, i, 3, v);
      acc(1, i, 1, ~v);
      cmp("err", 1, e);
      acc(0, i, 3, 0);
      cmp("data", v, r);
    end
    acc(1, 1, 3, 16'h1234);
    cmp("sub_wr", 0, e);
    acc(0, 1, 3, 0);
    cmp("sub_rd", 0, r);
    acc(0, 5, 3, 0);
    cmp("unmap", 1, e);
    v = $urandom;
    acc(1, 4, 3, v);
    @(posedge clk) px <= 1;
    @(posedge clk) px <= 0;
    acc(0, 3, 3, 0);
    cmp("xfer", v, r);
    @(posedge clk) md <= 1;
    for (i = 0; i < 32; i = i + 1)
    begin
      @(posedge clk) pw <= $urandom;
      lo <= $urandom;
      acc(1, 0, 1, {10'h003, i[4:3], 1'b1, i[2:0]});
      acc(0, 0, 1, 0);
      cmp("gate", {10'h003, i[4:3], 1'b1, i[2:0]}, r[7:0]);
      cmp("phase", ph_exp(i, i[3], i[4]), ph);
      cmp("shoot", 0, sh);
    end
    acc(1, 0, 3, 16'h00C7);
    cmp("word", 0, e);
    for (i = 0; i < 8; i = i + 1)
    begin
      @(posedge clk) rot <= i;
      wt(6);
      cmp("capture", ph_exp(i, 0, 0), ph);
    end
    acc(1, 0, 1, 16'h00B9);
    wt(1);
    cmp("ordin", pw, ph);
    @(posedge clk) md <= 2;
    v = $urandom;
    acc(1, 2, 3, v);
    acc(1, 3, 3, 16'h0100);
    @(posedge clk) rs <= 1;
    @(posedge clk) rs <= 0;
    #1 cmp("c3", v, c3);
    cmp("l3", 1, l3);
    @(posedge clk) {ld, lv} <= {1'b1, 16'h0105};
    @(posedge clk) {ld, dn} <= 2'b01;
    @(posedge clk) dn <= 0;
    for (i = 0; i < 30 && turn !== 1'b1; i = i + 1)
      wt(1);
    cmp("turn", 1, turn);
    report_and_stop;
  end
  initial begin
    #100000 bad_count = bad_count + 1;
    report_and_stop;
  end
endmodule // testbench
